// >>> verilog/dcp_top.sv
// digital control port: pin functions, fault latch, axi4-lite slave
// assumes trip and inhibit levels come from other domains and are synchronised here
// Contract
// (RQ1) three pins, each with its own independently chosen function
// (RQ2) every pin can be general bidirectional io with its own polarity bit
// (RQ3) one binary output word, one bit per bidirectional pin
// (RQ4) positive polarity: bit 1 drives high, bit 0 drives low
// (RQ5) negative polarity inverts both driven and sensed levels
// (RQ6) input word shows sensed level of bidirectional and input-only pins
// (RQ7) input and output words do not touch pins with other functions
// (RQ8) an input-only pin is never driven, whatever the output word holds
// (RQ9) fault function puts fault on pin 1, pin 2 becomes its return
// (RQ10) with fault function active the second pin's function is ignored
// (RQ11) fault asserts on any channel trip or an inhibit condition
// (RQ12) fault pin polarity selects the level of an active fault
// (RQ13) fault stays latched until cause is gone and protection is cleared
// (RQ14) trips held per channel until cleared; clearing restores the output
//
// Implementation choices: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/100ps
module dcp_top
    import dcp_pkg::*;
#(
    parameter int NPIN = 3,
    parameter int NCH  = 3
) (
    // clock and reset
    input  wire logic                  aclk,
    input  wire logic                  aresetn,
    // axi4-lite slave
    input  wire logic [DCP_AW-1:0]     s_axi_awaddr,
    input  wire logic                  s_axi_awvalid,
    output logic                       s_axi_awready,
    input  wire logic [DCP_DW-1:0]     s_axi_wdata,
    input  wire logic [DCP_DW/8-1:0]   s_axi_wstrb,
    input  wire logic                  s_axi_wvalid,
    output logic                       s_axi_wready,
    output logic [1:0]                 s_axi_bresp,
    output logic                       s_axi_bvalid,
    input  wire logic                  s_axi_bready,
    input  wire logic [DCP_AW-1:0]     s_axi_araddr,
    input  wire logic                  s_axi_arvalid,
    output logic                       s_axi_arready,
    output logic [DCP_DW-1:0]          s_axi_rdata,
    output logic [1:0]                 s_axi_rresp,
    output logic                       s_axi_rvalid,
    input  wire logic                  s_axi_rready,
    // port pins
    input  wire logic [NPIN-1:0]       pin_i,
    output logic [NPIN-1:0]            pin_o,
    output logic [NPIN-1:0]            pin_oe,
    // protection
    input  wire dcp_trip_s [NCH-1:0]   trip_in,
    input  wire logic                  inhibit_in,
    output logic [NCH-1:0]             chan_off,
    output logic                       fault,
    output logic                       irq
);
    localparam int TW = DCP_TRIP_W * NCH;
    localparam int SW = NPIN + TW + 1;
    localparam int ST_INH   = TW;
    localparam int ST_FAULT = TW + 1;
    localparam int CLR_INH  = NCH;
    localparam dcp_pin_cfg_s [NPIN-1:0] CFG_RST = {NPIN{DCP_PIN_CFG_RST}};

    // refused at elaboration: the register map cannot hold wider words
    if (NPIN < 2 || NPIN * DCP_CFG_W > DCP_DW || TW + 2 > DCP_DW || NCH < 1) begin : g_bad_param
        $error("dcp_top: NPIN or NCH out of range");
    end

    function automatic logic [DCP_DW-1:0] merge(input logic [DCP_DW-1:0] old,
                                               input logic [DCP_DW-1:0] nw,
                                               input logic [DCP_DW/8-1:0] st);
        logic [DCP_DW-1:0] m;
        m = '0;
        for (int b = 0; b < DCP_DW / 8; b++)
            m[8*b +: 8] = {8{st[b]}};
        return (old & ~m) | (nw & m);
    endfunction

    // two-stage synchroniser for pins, trips and inhibit
    logic [SW-1:0] sync1_q;
    logic [SW-1:0] sync2_q;
    logic [NPIN-1:0] s_pin;
    logic [TW-1:0]   s_trip;
    logic            s_inh;
    assign s_pin  = sync2_q[NPIN-1:0];
    assign s_trip = sync2_q[NPIN +: TW];
    assign s_inh  = sync2_q[SW-1];
    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            sync1_q <= '0;
            sync2_q <= '0;
        end else begin
            sync1_q <= {inhibit_in, trip_in, pin_i};
            sync2_q <= sync1_q;
        end
    end

    // bus and register state
    logic aw_got_q, aw_got_d, w_got_q, w_got_d;
    logic [DCP_AW-1:0] waddr_q, waddr_d;
    logic [DCP_DW-1:0] wdata_q, wdata_d, rdata_q, rdata_d;
    logic [DCP_DW/8-1:0] wstrb_q, wstrb_d;
    logic awready_q, awready_d, wready_q, wready_d, arready_q, arready_d;
    logic bvalid_q, bvalid_d, rvalid_q, rvalid_d;
    logic [1:0] bresp_q, bresp_d, rresp_q, rresp_d;
    dcp_pin_cfg_s [NPIN-1:0] cfg_q, cfg_d;
    logic [NPIN-1:0] out_q, out_d;
    logic [DCP_IRQ_W-1:0] en_q, en_d, irq_clr;
    logic [NCH:0] prot_clr;
    logic [NPIN-1:0] in_w;
    logic [TW-1:0] trip_q;
    logic inh_q, fault_q;
    logic [DCP_IRQ_W-1:0] ist_q;

    always_comb begin
        aw_got_d = aw_got_q;
        w_got_d  = w_got_q;
        waddr_d  = waddr_q;
        wdata_d  = wdata_q;
        wstrb_d  = wstrb_q;
        bvalid_d = bvalid_q;
        bresp_d  = bresp_q;
        rvalid_d = rvalid_q;
        rresp_d  = rresp_q;
        rdata_d  = rdata_q;
        cfg_d    = cfg_q;
        out_d    = out_q;
        en_d     = en_q;
        irq_clr  = '0;
        prot_clr = '0;
        if (bvalid_q && s_axi_bready)
            bvalid_d = 1'b0;
        if (s_axi_awvalid && awready_q) begin
            aw_got_d = 1'b1;
            waddr_d  = s_axi_awaddr;
        end
        if (s_axi_wvalid && wready_q) begin
            w_got_d = 1'b1;
            wdata_d = s_axi_wdata;
            wstrb_d = s_axi_wstrb;
        end
        // write happens once both halves are held
        if (aw_got_d && w_got_d && !bvalid_q) begin
            aw_got_d = 1'b0;
            w_got_d  = 1'b0;
            bvalid_d = 1'b1;
            bresp_d  = DCP_RESP_OKAY;
            unique case (waddr_d)
                DCP_A_PIN_CFG:   cfg_d = (NPIN*DCP_CFG_W)'(merge(DCP_DW'(cfg_q), wdata_d, wstrb_d)); // [RQ1] [RQ2]
                DCP_A_OUT_WORD:  out_d = NPIN'(merge(DCP_DW'(out_q), wdata_d, wstrb_d)); // [RQ3]
                DCP_A_PROT_CLR:  prot_clr = (NCH+1)'(merge('0, wdata_d, wstrb_d)); // [RQ14]
                DCP_A_IRQ_EN:    en_d = DCP_IRQ_W'(merge(DCP_DW'(en_q), wdata_d, wstrb_d));
                DCP_A_IRQ_CLR:   irq_clr = DCP_IRQ_W'(merge('0, wdata_d, wstrb_d));
                DCP_A_IN_WORD,
                DCP_A_TRIP_STAT,
                DCP_A_IRQ_STAT: ;
                default:         bresp_d = DCP_RESP_SLVERR;
            endcase
        end
        if (rvalid_q && s_axi_rready)
            rvalid_d = 1'b0;
        if (s_axi_arvalid && arready_q) begin
            rvalid_d = 1'b1;
            rresp_d  = DCP_RESP_OKAY;
            unique case (s_axi_araddr)
                DCP_A_PIN_CFG:   rdata_d = DCP_DW'(cfg_q);
                DCP_A_OUT_WORD:  rdata_d = DCP_DW'(out_q);
                DCP_A_IN_WORD:   rdata_d = DCP_DW'(in_w); // [RQ6]
                DCP_A_TRIP_STAT: rdata_d = DCP_DW'({fault_q, inh_q, trip_q});
                DCP_A_IRQ_STAT:  rdata_d = DCP_DW'(ist_q);
                DCP_A_IRQ_EN:    rdata_d = DCP_DW'(en_q);
                DCP_A_PROT_CLR,
                DCP_A_IRQ_CLR:   rdata_d = '0;
                default: begin
                    rdata_d = '0;
                    rresp_d = DCP_RESP_SLVERR;
                end
            endcase
        end
        awready_d = !aw_got_d && !bvalid_d;
        wready_d  = !w_got_d && !bvalid_d;
        arready_d = !rvalid_d;
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            aw_got_q  <= 1'b0;
            w_got_q   <= 1'b0;
            waddr_q   <= '0;
            wdata_q   <= '0;
            wstrb_q   <= '0;
            awready_q <= 1'b0;
            wready_q  <= 1'b0;
            arready_q <= 1'b0;
            bvalid_q  <= 1'b0;
            bresp_q   <= DCP_RESP_OKAY;
            rvalid_q  <= 1'b0;
            rresp_q   <= DCP_RESP_OKAY;
            rdata_q   <= '0;
            cfg_q     <= CFG_RST;
            out_q     <= '0;
            en_q      <= '0;
        end else begin
            aw_got_q  <= aw_got_d;
            w_got_q   <= w_got_d;
            waddr_q   <= waddr_d;
            wdata_q   <= wdata_d;
            wstrb_q   <= wstrb_d;
            awready_q <= awready_d;
            wready_q  <= wready_d;
            arready_q <= arready_d;
            bvalid_q  <= bvalid_d;
            bresp_q   <= bresp_d;
            rvalid_q  <= rvalid_d;
            rresp_q   <= rresp_d;
            rdata_q   <= rdata_d;
            cfg_q     <= cfg_d;
            out_q     <= out_d;
            en_q      <= en_d;
        end
    end

    // pins, protection latches, interrupts
    logic [TW-1:0] trip_d;
    logic inh_d, fault_d, irq_q, irq_d;
    logic [NPIN-1:0] pin_o_q, pin_o_d, pin_oe_q, pin_oe_d, in_q;
    logic [DCP_IRQ_W-1:0] ist_d;
    logic fault_sel;
    logic [NPIN-1:0] is_gp, is_in;
    logic [NCH-1:0]  chan_off_q, chan_off_d;

    always_comb begin
        // set wins over clear, so a trip still present survives the clear
        for (int b = 0; b < TW; b++)
            trip_d[b] = s_trip[b] | (trip_q[b] & !prot_clr[b / DCP_TRIP_W]); // [RQ14]
        inh_d   = s_inh | (inh_q & !prot_clr[CLR_INH]);
        fault_d = (|trip_d) | inh_d; // [RQ11] [RQ13]
        fault_sel = cfg_q[0].func == DCP_FN_FAULT_OUT;
        for (int i = 0; i < NPIN; i++) begin
            // second pin is the fault return while the fault function runs
            is_gp[i] = cfg_q[i].func == DCP_FN_GENERAL_IO && !(i == 1 && fault_sel); // [RQ10]
            is_in[i] = cfg_q[i].func == DCP_FN_INPUT_ONLY && !(i == 1 && fault_sel);
            in_w[i]  = (is_gp[i] || is_in[i]) ? (s_pin[i] ^ cfg_q[i].neg) : 1'b0; // [RQ5] [RQ6] [RQ7]
            pin_oe_d[i] = is_gp[i]; // [RQ8]
            pin_o_d[i]  = is_gp[i] ? (out_q[i] ^ cfg_q[i].neg) : 1'b0; // [RQ4] [RQ5] [RQ7]
        end
        if (fault_sel) begin
            pin_oe_d[0] = 1'b1; // [RQ9]
            pin_o_d[0]  = fault_d ^ cfg_q[0].neg; // [RQ12]
        end
        ist_d = ist_q & ~irq_clr;
        ist_d[DCP_IRQ_FAULT] = ist_d[DCP_IRQ_FAULT] | (fault_d & !fault_q);
        ist_d[DCP_IRQ_INCHG] = ist_d[DCP_IRQ_INCHG] | (|(in_w ^ in_q));
        irq_d = |(ist_d & en_d);
    end

    always_ff @(posedge aclk) begin
        if (!aresetn) begin
            trip_q   <= '0;
            inh_q    <= 1'b0;
            fault_q  <= 1'b0;
            pin_o_q  <= '0;
            pin_oe_q <= '0;
            in_q     <= '0;
            ist_q    <= '0;
            irq_q    <= 1'b0;
            chan_off_q <= '0;
        end else begin
            trip_q   <= trip_d;
            inh_q    <= inh_d;
            fault_q  <= fault_d;
            pin_o_q  <= pin_o_d;
            pin_oe_q <= pin_oe_d;
            in_q     <= in_w;
            ist_q    <= ist_d;
            irq_q    <= irq_d;
            chan_off_q <= chan_off_d;
        end
    end

    assign s_axi_awready = awready_q;
    assign s_axi_wready  = wready_q;
    assign s_axi_bvalid  = bvalid_q;
    assign s_axi_bresp   = bresp_q;
    assign s_axi_arready = arready_q;
    assign s_axi_rvalid  = rvalid_q;
    assign s_axi_rresp   = rresp_q;
    assign s_axi_rdata   = rdata_q;
    assign pin_o  = pin_o_q;
    assign pin_oe = pin_oe_q;
    assign fault  = fault_q;
    assign irq    = irq_q;
    assign chan_off = chan_off_q;
    // registered from the next trip state, so it moves in step with trip_q
    generate
        for (genvar c = 0; c < NCH; c++) begin : g_off
            assign chan_off_d[c] = |trip_d[DCP_TRIP_W*c +: DCP_TRIP_W]; // [RQ14]
        end
    endgenerate

    fault_sum_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ11]
        fault_q == ((|trip_q) | inh_q)) else $error("fault not the sum of latches");
    trip_catch_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ14]
        ##1 ((trip_q & $past(s_trip)) == $past(s_trip))) else $error("trip lost");
    fault_hold_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ13]
        fault_q && prot_clr == '0 |=> fault_q) else $error("fault dropped without clear");
    fault_pin_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ9] [RQ12]
        fault_sel |=> pin_oe_q[0] && pin_o_q[0] == (fault_q ^ $past(cfg_q[0].neg)))
        else $error("fault pin wrong");
    fault_return_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ10]
        fault_sel |=> !pin_oe_q[1] && !in_q[1]) else $error("fault return pin used");
    generate
        for (genvar p = 0; p < NPIN; p++) begin : g_chk
            input_undriven_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ8]
                cfg_q[p].func == DCP_FN_INPUT_ONLY |=> !pin_oe_q[p]) else $error("input pin driven");
            gp_drive_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ4] [RQ5]
                is_gp[p] |=> pin_oe_q[p] && pin_o_q[p] == ($past(out_q[p]) ^ $past(cfg_q[p].neg)))
                else $error("io pin level wrong");
            other_quiet_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ7]
                cfg_q[p].func == DCP_FN_OTHER && !(p == 0) |=> !pin_oe_q[p] && !in_q[p])
                else $error("other pin touched");
            in_sense_a: assert property (@(posedge aclk) disable iff (!aresetn) // [RQ6]
                is_in[p] |=> in_q[p] == ($past(s_pin[p]) ^ $past(cfg_q[p].neg)))
                else $error("input word wrong");
        end
    endgenerate
endmodule

// >>> verilog/dcp_pkg.sv
// digital control port: register map, pin functions, carrier types
// assumes a 32-bit axi4-lite bus with 8-bit byte addresses
package dcp_pkg;
    localparam int DCP_AW      = 8;
    localparam int DCP_DW      = 32;
    localparam int DCP_TRIP_W  = 3;
    localparam int DCP_CFG_W   = 3;
    localparam int DCP_IRQ_W   = 2;
    // byte addresses
    localparam logic [DCP_AW-1:0] DCP_A_PIN_CFG   = 8'h00;
    localparam logic [DCP_AW-1:0] DCP_A_OUT_WORD  = 8'h04;
    localparam logic [DCP_AW-1:0] DCP_A_IN_WORD   = 8'h08;
    localparam logic [DCP_AW-1:0] DCP_A_TRIP_STAT = 8'h0c;
    localparam logic [DCP_AW-1:0] DCP_A_PROT_CLR  = 8'h10;
    localparam logic [DCP_AW-1:0] DCP_A_IRQ_STAT  = 8'h14;
    localparam logic [DCP_AW-1:0] DCP_A_IRQ_EN    = 8'h18;
    localparam logic [DCP_AW-1:0] DCP_A_IRQ_CLR   = 8'h1c;
    // interrupt status bits
    localparam int DCP_IRQ_FAULT = 0;
    localparam int DCP_IRQ_INCHG = 1;
    localparam logic [1:0] DCP_RESP_OKAY   = 2'h0;
    localparam logic [1:0] DCP_RESP_SLVERR = 2'h2;
    typedef enum logic [1:0] {
        DCP_FN_GENERAL_IO = 2'b00,
        DCP_FN_INPUT_ONLY = 2'b01,
        DCP_FN_FAULT_OUT  = 2'b10,
        DCP_FN_OTHER      = 2'b11
    } dcp_func_e;
    typedef struct packed {
        logic      neg;
        dcp_func_e func;
    } dcp_pin_cfg_s;
    typedef struct packed {
        logic overtemperature_trip;
        logic overcurrent_trip;
        logic overvoltage_trip;
    } dcp_trip_s;
    localparam dcp_pin_cfg_s DCP_PIN_CFG_RST = '{neg: 1'b0, func: DCP_FN_INPUT_ONLY};
endpackage

// >>> sim/dcp_ext_model.sv
// external relay or logic circuit on the three port pins
// assumes the bench sets ext_en and ext_val just after clock edges
`timescale 1ns/100ps
module dcp_ext_model (
    // module side
    input  wire logic [2:0] pin_o,
    input  wire logic [2:0] pin_oe,
    // external drivers
    input  wire logic [2:0] ext_val,
    input  wire logic [2:0] ext_en,
    // sensed level back to the module
    output logic      [2:0] pin_i
);
    // pull-up on idle lines, so a released pin never keeps its last level
    always_comb begin
        for (int i = 0; i < 3; i++) begin
            pin_i[i] = pin_oe[i] ? pin_o[i] : (ext_en[i] ? ext_val[i] : 1'b1);
        end
    end
endmodule

// >>> sim/dcp_top_tb_top.sv
// bench for the digital control port: axi4-lite tasks, pin and fault tests
// assumes dcp_top and dcp_ext_model; 125 MHz clock, sync low reset
`timescale 1ns/100ps
module dcp_top_tb_top
    import dcp_pkg::*;
;
    logic              aclk, aresetn, awvalid, awready, wvalid, wready, bvalid, bready;
    logic              arvalid, arready, rvalid, rready, inhibit_in, fault, irq;
    logic [DCP_AW-1:0] awaddr, araddr;
    logic [DCP_DW-1:0] wdata, rdata, r;
    logic [1:0]        bresp, rresp;
    logic [2:0]        pin_i, pin_o, pin_oe, ext_val, ext_en, chan_off;
    dcp_trip_s [2:0]   trip_in;
    int                mismatches, checks;

    dcp_top dut_u (.aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hf), .s_axi_wvalid(wvalid),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .pin_i(pin_i), .pin_o(pin_o),
        .pin_oe(pin_oe), .trip_in(trip_in), .inhibit_in(inhibit_in), .chan_off(chan_off),
        .fault(fault), .irq(irq));
    dcp_ext_model ext_u (.pin_o(pin_o), .pin_oe(pin_oe), .ext_val(ext_val), .ext_en(ext_en), .pin_i(pin_i));

    always #4 aclk = ~aclk;

    task automatic end_of_test();
        $display("checks=%0d mismatches=%0d", checks, mismatches);
        if (mismatches == 0 && checks > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks++;
        if (got !== exp) begin
            mismatches++;
            $display("[ERR] t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic wt(input int k);
        repeat (k) @(posedge aclk);
    endtask
    // write: both channels offered together, each dropped once taken
    task automatic wr(input logic [7:0] a, input logic [31:0] d, input logic [1:0] er = DCP_RESP_OKAY);
        bit done;
        done = 1'b0;
        awaddr <= a;
        wdata <= d;
        awvalid <= 1'b1;
        wvalid <= 1'b1;
        bready <= 1'b1;
        for (int n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (awready) awvalid <= 1'b0;
            if (wready) wvalid <= 1'b0;
            if (bvalid) begin
                bready <= 1'b0;
                done = 1'b1;
                chk({30'h0, bresp}, {30'h0, er});
            end
        end
        if (!done) begin
            mismatches++;
            end_of_test();
        end
        @(posedge aclk);
    endtask
    task automatic rd(input logic [7:0] a, output logic [31:0] d, input logic [1:0] er = DCP_RESP_OKAY);
        bit done;
        done = 1'b0;
        araddr <= a;
        arvalid <= 1'b1;
        rready <= 1'b1;
        for (int n = 0; n < 60 && !done; n++) begin
            @(posedge aclk);
            if (arready) arvalid <= 1'b0;
            if (rvalid) begin
                rready <= 1'b0;
                done = 1'b1;
                d = rdata;
                chk({30'h0, rresp}, {30'h0, er});
            end
        end
        if (!done) begin
            mismatches++;
            end_of_test();
        end
        @(posedge aclk);
    endtask

    initial begin
        {aclk, aresetn, awvalid, wvalid, bready, arvalid, rready, inhibit_in} = '0;
        {awaddr, araddr, wdata, ext_val, ext_en, trip_in} = '0;
        mismatches = 0;
        checks = 0;
        repeat (2) @(posedge aclk);
        aresetn <= 1'b1;
        wt(2);
        rd(DCP_A_PIN_CFG, r); chk(r, 32'h49);
        rd(DCP_A_OUT_WORD, r); chk(r, 32'h0);
        chk({29'h0, pin_oe}, 32'h0);
        rd(8'h40, r, DCP_RESP_SLVERR); chk(r, 32'h0);
        wr(8'h44, 32'hff, DCP_RESP_SLVERR);
        // all general io, pin1 negative: driven level and read-back per word
        wr(DCP_A_PIN_CFG, 32'h20);
        for (int v = 0; v < 8; v++) begin
            wr(DCP_A_OUT_WORD, 32'(v));
            wt(4);
            chk({29'h0, pin_oe}, 32'h7);
            chk({29'h0, pin_o}, 32'(v ^ 2));
            rd(DCP_A_IN_WORD, r); chk(r, 32'(v));
        end
        // input-only, pin2 negative: never driven, input word follows the far side; all other: never driven, word 0
        ext_en <= 3'h7;
        ext_val <= 3'h3;
        wr(DCP_A_PIN_CFG, 32'h149);
        wr(DCP_A_OUT_WORD, 32'h7);
        wt(4);
        chk({29'h0, pin_oe}, 32'h0);
        rd(DCP_A_IN_WORD, r); chk(r, 32'h7);
        wr(DCP_A_IRQ_CLR, 32'h3);
        rd(DCP_A_IRQ_STAT, r); chk(r & 32'h2, 32'h0);
        ext_val <= 3'h6;
        wt(4);
        rd(DCP_A_IN_WORD, r); chk(r, 32'h2);
        rd(DCP_A_IRQ_STAT, r); chk(r & 32'h2, 32'h2);
        wr(DCP_A_PIN_CFG, 32'hdb);
        wt(4);
        chk({29'h0, pin_oe}, 32'h0);
        rd(DCP_A_IN_WORD, r); chk(r, 32'h0);
        ext_en <= 3'h0;
        // fault on pin0, pin1 set to general io yet left alone; each trip kind once
        wr(DCP_A_IRQ_EN, 32'h1);
        for (int i = 0; i < 3; i++) begin
            wr(DCP_A_PIN_CFG, (i == 2) ? 32'h6 : 32'h2);
            wr(DCP_A_IRQ_CLR, 32'h3);
            trip_in[i] <= dcp_trip_s'(3'b001 << i);
            wt(4);
            chk({29'h0, pin_oe}, 32'h5);
            chk({31'h0, fault}, 32'h1);
            chk({29'h0, chan_off}, 32'(1 << i));
            chk({31'h0, pin_o[0]}, (i == 2) ? 32'h0 : 32'h1);
            chk({31'h0, irq}, 32'h1);
            rd(DCP_A_TRIP_STAT, r); chk(r, 32'(1 << (4 * i)) | 32'h400);
            trip_in[i] <= '0;
            wt(4);
            chk({31'h0, fault}, 32'h1);
            wr(DCP_A_PROT_CLR, 32'(1 << i));
            wt(2);
            chk({31'h0, fault}, 32'h0);
            chk({29'h0, chan_off}, 32'h0);
            chk({31'h0, pin_o[0]}, (i == 2) ? 32'h1 : 32'h0);
        end
        // inhibit: clear refused while present, irq masked, then cleared
        wr(DCP_A_IRQ_CLR, 32'h3);
        inhibit_in <= 1'b1;
        wt(4);
        chk({31'h0, irq}, 32'h1);
        rd(DCP_A_TRIP_STAT, r); chk(r, 32'h600);
        wr(DCP_A_PROT_CLR, 32'h8);
        wt(2);
        chk({31'h0, fault}, 32'h1);
        wr(DCP_A_IRQ_EN, 32'h0);
        chk({31'h0, irq}, 32'h0);
        rd(DCP_A_IRQ_STAT, r); chk(r & 32'h1, 32'h1);
        inhibit_in <= 1'b0;
        wt(4);
        wr(DCP_A_PROT_CLR, 32'h8);
        wr(DCP_A_IRQ_CLR, 32'h3);
        wt(2);
        chk({31'h0, fault}, 32'h0);
        rd(DCP_A_IRQ_STAT, r); chk(r & 32'h1, 32'h0);
        end_of_test();
    end
endmodule
